//--- hdl/aerl_top.sv
// root port advanced error logging registers with a wishbone slave
// assumes all event inputs come from logic on CLK_IN; the warm
// reset pin is asynchronous and is synchronised here
//
// The Wishbone interface to the registers was chosen for this implementation.
module aerl_top
  import aerl_pkg::*;
(
  // clock and resets
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic WARM_RST_N_IN,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [11:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // detected error events, one-cycle pulses
  input wire logic [4:0] COR_ERR_IN,
  input wire logic [31:0] UNCOR_ERR_IN,
  input wire logic [31:0] UNCOR_SEV_IN,
  input wire logic [15:0] SELF_ID_IN,
  input wire logic [31:0] HDR0_IN,
  input wire logic [31:0] HDR1_IN,
  input wire logic [31:0] HDR2_IN,
  input wire logic [31:0] HDR3_IN,
  input wire logic LOG_UNLOCK_IN,
  // received error messages
  input wire logic MSG_VALID_IN,
  input wire logic [1:0] MSG_TYPE_IN,
  input wire logic [15:0] MSG_RID_IN,
  input wire logic [4:0] MSG_NUM_IN,
  // results
  output logic [4:0] COR_LOG_OUT,
  output logic [2:0] REPORT_OUT,
  output logic [31:0] SEVERITY_OUT
);
  import aerl_pkg::*;

  // ---------------------------------------------------------
  // state
  // ---------------------------------------------------------
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic wrst_s1_r, wrst_s2_r;
  logic [31:0] cor_r, cor_nxt, msk_r, msk_nxt;
  logic [31:0] sev_r, sev_nxt, cmd_r, cmd_nxt;
  logic [4:0] log_r, log_nxt;
  logic [31:0] rs_r, rs_nxt;
  logic [15:0] sid_unc_r, sid_unc_nxt, sid_cor_r, sid_cor_nxt;
  logic [2:0] rep_r, rep_nxt;
  logic lock_r, lock_nxt;
  logic [PTR_W-1:0] ptr_r, ptr_nxt;
  logic [31:0] hdr_r [4];
  logic [31:0] hdr_nxt [4];

  // ---------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------
  logic hit, wr;
  logic [31:0] bmask, wbits;
  logic [4:0] msk5;
  logic [31:0] cor_ev;

  // one access per request; ack drops the cycle after
  always_comb begin
    hit = WB_CYC_IN & WB_STB_IN & ~ack_r;
    wr = hit & WB_WE_IN;
    bmask = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}},
             {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
    wbits = WB_DAT_IN & bmask;
    ack_nxt = hit;
    rdat_nxt = rdat_r;
    if (hit && !WB_WE_IN) begin
      case (WB_ADR_IN)
        OFS_SEV: rdat_nxt = sev_r;
        OFS_COR_STS: rdat_nxt = cor_r;
        OFS_COR_MSK: rdat_nxt = msk_r;
        // crc bits 8:5 always zero, pointer below
        OFS_CAP_CTRL: rdat_nxt = {27'h0, ptr_r};
        OFS_HDR0: rdat_nxt = hdr_r[0];
        OFS_HDR1: rdat_nxt = hdr_r[1];
        OFS_HDR2: rdat_nxt = hdr_r[2];
        OFS_HDR3: rdat_nxt = hdr_r[3];
        OFS_ROOT_CMD: rdat_nxt = cmd_r;
        // message number from configuration
        OFS_ROOT_STS: rdat_nxt = {MSG_NUM_IN, 20'h0, rs_r[6:0]};
        OFS_SRC_ID: rdat_nxt = {sid_unc_r, sid_cor_r};
        default: rdat_nxt = 32'h00000000;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // ---------------------------------------------------------
  // warm reset synchroniser
  // ---------------------------------------------------------
  // warm reset only touches non-sticky state
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wrst_s1_r <= 1'b0;
      wrst_s2_r <= 1'b0;
    end else begin
      wrst_s1_r <= WARM_RST_N_IN;
      wrst_s2_r <= wrst_s1_r;
    end
  end

  // ---------------------------------------------------------
  // correctable status, mask, severity, command
  // ---------------------------------------------------------
  always_comb begin
    cor_ev = 32'h00000000;
    cor_ev[COR_RX] = COR_ERR_IN[0];
    cor_ev[COR_TLP] = COR_ERR_IN[1];
    cor_ev[COR_DLLP] = COR_ERR_IN[2];
    cor_ev[COR_ROLL] = COR_ERR_IN[3];
    cor_ev[COR_REPLAY] = COR_ERR_IN[4];
    msk5 = {msk_r[COR_REPLAY], msk_r[COR_ROLL], msk_r[COR_DLLP],
            msk_r[COR_TLP], msk_r[COR_RX]};
    // every event lands, and a set beats a same-cycle clear
    cor_nxt = cor_r;
    if (wr && WB_ADR_IN == OFS_COR_STS) begin
      cor_nxt = cor_r & ~wbits;
    end
    cor_nxt = (cor_nxt | cor_ev) & COR_BITS;
    msk_nxt = msk_r;
    if (wr && WB_ADR_IN == OFS_COR_MSK) begin
      msk_nxt = ((msk_r & ~bmask) | wbits) & COR_BITS;
    end
    // mask blocks forwarding only, never the status
    log_nxt = COR_ERR_IN & ~msk5;
    // bit 0 stays writable and sev_eff reads it like bits 4 and 5
    sev_nxt = sev_r;
    if (wr && WB_ADR_IN == OFS_SEV) begin
      sev_nxt = ((sev_r & ~bmask) | wbits) & SEV_BITS;
    end
    cmd_nxt = cmd_r;
    if (wr && WB_ADR_IN == OFS_ROOT_CMD) begin
      cmd_nxt = ((cmd_r & ~bmask) | wbits) & CMD_BITS;
    end
    if (!wrst_s2_r) begin
      cmd_nxt = 32'h00000000;
    end
  end

  // sticky status, mask and severity reset only on power-on reset; the command also clears on warm reset
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cor_r <= 32'h00000000;
      msk_r <= 32'h00000000;
      sev_r <= SEV_RST;
      cmd_r <= 32'h00000000;
      log_r <= 5'h00;
    end else begin
      cor_r <= cor_nxt;
      msk_r <= msk_nxt;
      sev_r <= sev_nxt;
      cmd_r <= cmd_nxt;
      log_r <= log_nxt;
    end
  end

  // ---------------------------------------------------------
  // root error status and source ids
  // ---------------------------------------------------------
  logic msg_cor, msg_nf, msg_fat, msg_unc;
  logic self_cor, self_fat, self_nf, self_unc;
  logic cor_any, unc_any, fat_any, nf_any;
  logic [31:0] sev_eff;

  always_comb begin
    msg_cor = MSG_VALID_IN && MSG_TYPE_IN == MSG_COR;
    msg_nf = MSG_VALID_IN && MSG_TYPE_IN == MSG_NF;
    msg_fat = MSG_VALID_IN && MSG_TYPE_IN == MSG_FAT;
    msg_unc = msg_nf | msg_fat;
    // own errors count as messages from ourselves
    sev_eff = (UNCOR_SEV_IN & ~SEV_BITS) | sev_r;
    self_cor = |log_nxt;
    self_fat = |(UNCOR_ERR_IN & sev_eff);
    self_nf = |(UNCOR_ERR_IN & ~sev_eff);
    self_unc = self_fat | self_nf;
    cor_any = msg_cor | self_cor;
    unc_any = msg_unc | self_unc;
    fat_any = msg_fat | self_fat;
    nf_any = msg_nf | self_nf;
    // clear first so a new event in the same cycle wins
    rs_nxt = rs_r;
    if (wr && WB_ADR_IN == OFS_ROOT_STS) begin
      rs_nxt = rs_r & ~(wbits & RS_W1C);
    end
    sid_cor_nxt = sid_cor_r;
    sid_unc_nxt = sid_unc_r;
    // enables gate only the report pulses at the end, never the logging
    if (cor_any) begin
      if (!rs_nxt[RS_FIRST_COR]) begin
        rs_nxt[RS_FIRST_COR] = 1'b1;
        sid_cor_nxt = msg_cor ? MSG_RID_IN : SELF_ID_IN;
        rs_nxt[RS_MULT_COR] = rs_nxt[RS_MULT_COR] | (msg_cor & self_cor);
      end else begin
        rs_nxt[RS_MULT_COR] = 1'b1; // id dropped
      end
    end
    if (unc_any) begin
      if (!rs_nxt[RS_FIRST_UNC]) begin
        rs_nxt[RS_FIRST_UNC] = 1'b1;
        sid_unc_nxt = msg_unc ? MSG_RID_IN : SELF_ID_IN;
        // fatal flag follows the event that became first
        rs_nxt[RS_FIRST_FAT] = msg_unc ? msg_fat : self_fat;
        rs_nxt[RS_MULT_UNC] = rs_nxt[RS_MULT_UNC] | (msg_unc & self_unc);
      end else begin
        rs_nxt[RS_MULT_UNC] = 1'b1;
      end
    end
    rs_nxt[RS_FAT_RCVD] = rs_nxt[RS_FAT_RCVD] | fat_any;
    rs_nxt[RS_NF_RCVD] = rs_nxt[RS_NF_RCVD] | nf_any;
    rs_nxt = rs_nxt & RS_W1C;
    // enabled category pulses toward the interrupt logic
    rep_nxt = {fat_any & cmd_r[2], nf_any & cmd_r[1], cor_any & cmd_r[0]};
  end

  // root status registers
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rs_r <= 32'h00000000;
      sid_cor_r <= 16'h0000;
      sid_unc_r <= 16'h0000;
      rep_r <= 3'h0;
    end else begin
      rs_r <= rs_nxt;
      sid_cor_r <= sid_cor_nxt;
      sid_unc_r <= sid_unc_nxt;
      rep_r <= rep_nxt;
    end
  end

  // ---------------------------------------------------------
  // first error pointer and header log
  // ---------------------------------------------------------
  logic lock_eff, cap;

  // the log stays frozen until the owner of the status unlocks it
  always_comb begin
    lock_eff = lock_r & ~LOG_UNLOCK_IN;
    cap = (|UNCOR_ERR_IN) & ~lock_eff;
    lock_nxt = lock_eff | cap;
    ptr_nxt = ptr_r;
    hdr_nxt = hdr_r;
    if (cap) begin
      // ascending scan leaves the leftmost bit
      for (int i = 0; i < 32; i++) begin
        if (UNCOR_ERR_IN[i]) begin
          ptr_nxt = PTR_W'(i);
        end
      end
      // later headers cannot reach a locked log
      hdr_nxt[0] = HDR0_IN;
      hdr_nxt[1] = HDR1_IN;
      hdr_nxt[2] = HDR2_IN;
      hdr_nxt[3] = HDR3_IN;
    end
  end

  // log registers, one per dword
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_hdr
      always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          hdr_r[g] <= 32'h00000000;
        end else begin
          hdr_r[g] <= hdr_nxt[g];
        end
      end
    end
  endgenerate

  // lock and pointer
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lock_r <= 1'b0;
      ptr_r <= '0;
    end else begin
      lock_r <= lock_nxt;
      ptr_r <= ptr_nxt;
    end
  end

  // ---------------------------------------------------------
  // outputs
  // ---------------------------------------------------------
  assign WB_ACK_OUT = ack_r;
  assign WB_DAT_OUT = rdat_r;
  assign COR_LOG_OUT = log_r;
  assign REPORT_OUT = rep_r;
  assign SEVERITY_OUT = sev_r;

  // ---------------------------------------------------------
  // assertions
  // ---------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  logic clr_rs, clr_cor;
  assign clr_rs = wr && WB_ADR_IN == OFS_ROOT_STS;
  assign clr_cor = wr && WB_ADR_IN == OFS_COR_STS;

  replay_flag_a: assert property (COR_ERR_IN[4] |=> cor_r[12])
    else $error("replay timeout not recorded");
  multi_cor_a: assert property (&COR_ERR_IN |=> cor_r == COR_BITS)
    else $error("simultaneous correctable lost");
  mask_gate_a: assert property (##1 COR_LOG_OUT == ($past(COR_ERR_IN) & ~$past(msk5)))
    else $error("mask gating wrong");
  // only reads reload the data register, so writes stay out of this check
  crc_zero_a: assert property ($past(hit && !WB_WE_IN) &&
    $past(WB_ADR_IN) == OFS_CAP_CTRL |-> WB_DAT_OUT[8:5] == 4'h0)
    else $error("crc bits not zero");
  sev_hold_a: assert property (!(wr && WB_ADR_IN == OFS_SEV) |=> $stable(sev_r))
    else $error("severity changed without write");
  // pointed bit must be set and nothing above it
  ptr_left_a: assert property (cap |=>
    ($past(UNCOR_ERR_IN) >> ptr_r) == 32'h1)
    else $error("pointer not leftmost");
  hdr_frozen_a: assert property (lock_r && !LOG_UNLOCK_IN |=> $stable(hdr_r[0]) && $stable(ptr_r))
    else $error("header log overwritten");
  first_cor_a: assert property (msg_cor && !self_cor && !rs_r[0] |=>
    rs_r[0] && sid_cor_r == $past(MSG_RID_IN))
    else $error("first correctable not logged");
  next_cor_a: assert property (msg_cor && rs_r[0] && !clr_rs |=> rs_r[1] && $stable(sid_cor_r))
    else $error("second correctable mishandled");
  first_unc_a: assert property (msg_fat && !self_unc && !rs_r[2] |=> rs_r[2] && rs_r[4] && rs_r[6])
    else $error("first fatal not logged");
  next_unc_a: assert property (msg_nf && rs_r[2] && !clr_rs |=> rs_r[3] && rs_r[5] && $stable(sid_unc_r))
    else $error("second uncorrectable mishandled");
  w1c_clear_a: assert property (clr_rs && wbits[0] && !cor_any |=> !rs_r[0])
    else $error("write one did not clear");
  w1c_keep_a: assert property (clr_cor && !wbits[12] && cor_r[12] |=> cor_r[12])
    else $error("write zero cleared a flag");
  ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held two cycles");
endmodule

//--- inc/aerl_pkg.sv
// constants for the root port error logging block
// assumes byte addressing of a 4 KiB configuration space
package aerl_pkg;
  // ---------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------
  localparam logic [11:0] OFS_SEV = 12'h10C;
  localparam logic [11:0] OFS_COR_STS = 12'h110;
  localparam logic [11:0] OFS_COR_MSK = 12'h114;
  localparam logic [11:0] OFS_CAP_CTRL = 12'h118;
  localparam logic [11:0] OFS_HDR0 = 12'h11C;
  localparam logic [11:0] OFS_HDR1 = 12'h120;
  localparam logic [11:0] OFS_HDR2 = 12'h124;
  localparam logic [11:0] OFS_HDR3 = 12'h128;
  localparam logic [11:0] OFS_ROOT_CMD = 12'h12C;
  localparam logic [11:0] OFS_ROOT_STS = 12'h130;
  localparam logic [11:0] OFS_SRC_ID = 12'h134;
  // ---------------------------------------------------------
  // field positions and masks
  // ---------------------------------------------------------
  localparam int COR_RX = 0;
  localparam int COR_TLP = 6;
  localparam int COR_DLLP = 7;
  localparam int COR_ROLL = 8;
  localparam int COR_REPLAY = 12;
  localparam logic [31:0] COR_BITS = 32'h000011C1;
  localparam logic [31:0] SEV_BITS = 32'h00000031;
  localparam logic [31:0] SEV_RST = 32'h00000011;
  localparam logic [31:0] CMD_BITS = 32'h00000007;
  localparam int RS_FIRST_COR = 0;
  localparam int RS_MULT_COR = 1;
  localparam int RS_FIRST_UNC = 2;
  localparam int RS_MULT_UNC = 3;
  localparam int RS_FIRST_FAT = 4;
  localparam int RS_NF_RCVD = 5;
  localparam int RS_FAT_RCVD = 6;
  localparam logic [31:0] RS_W1C = 32'h0000007F;
  localparam int MSGNUM_LSB = 27;
  localparam int PTR_W = 5;
  // ---------------------------------------------------------
  // received message types
  // ---------------------------------------------------------
  localparam logic [1:0] MSG_COR = 2'h0;
  localparam logic [1:0] MSG_NF = 2'h1;
  localparam logic [1:0] MSG_FAT = 2'h2;
endpackage

//--- verification/aerl_link_model.sv
// link side model: detected error pulses and received messages
// assumes one bench process calls ev on the core clock
module aerl_link_model (
  // clock
  input wire logic clk_in,
  // detected errors
  output logic [4:0] cor_out,
  output logic [31:0] unc_out,
  output logic [31:0] sev_out,
  output logic [31:0] hdr_out [4],
  output logic unlock_out,
  // received messages
  output logic mv_out,
  output logic [1:0] mt_out,
  output logic [15:0] rid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // idle levels
  // ----
  initial begin
    cor_out = 5'h00;
    unc_out = 32'h0;
    sev_out = 32'h0;
    hdr_out = '{default: 32'h0};
    unlock_out = 1'b0;
    mv_out = 1'b0;
    mt_out = 2'h0;
    rid_out = 16'h0;
  end
  // one pulse cycle; released data lines invert so stale values never match
  task automatic ev(input logic [4:0] c, input logic [31:0] u, input logic [31:0] s,
    input logic ul, input logic mv, input logic [1:0] mt, input logic [15:0] rid,
    input logic [127:0] h);
    @(posedge clk_in);
    cor_out <= c;
    unc_out <= u;
    sev_out <= s;
    unlock_out <= ul;
    mv_out <= mv;
    mt_out <= mt;
    rid_out <= rid;
    for (int i = 0; i < 4; i++) hdr_out[i] <= h[32*i +: 32];
    @(posedge clk_in);
    cor_out <= 5'h00;
    unc_out <= 32'h0;
    unlock_out <= 1'b0;
    mv_out <= 1'b0;
    mt_out <= ~mt;
    rid_out <= ~rid;
    for (int i = 0; i < 4; i++) hdr_out[i] <= ~h[32*i +: 32];
  endtask
endmodule

//--- verification/testbench.sv
// self-checking bench for the root port error logging registers
// assumes the link model drives events; wishbone sel is all bytes but for one masked write
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import aerl_pkg::*;
  logic CLK_IN = 1'b0;
  logic RST_N_IN = 1'b0;
  logic WARM_RST_N_IN = 1'b1;
  logic WB_CYC_IN = 1'b0, WB_STB_IN = 1'b0, WB_WE_IN = 1'b0, WB_ACK_OUT;
  logic [11:0] WB_ADR_IN = 12'h000;
  logic [3:0] WB_SEL_IN = 4'hF;
  logic [31:0] WB_DAT_IN = 32'h0, WB_DAT_OUT, UNCOR_ERR_IN, UNCOR_SEV_IN, SEVERITY_OUT;
  logic [31:0] hdr [4];
  logic LOG_UNLOCK_IN, MSG_VALID_IN;
  logic [4:0] COR_ERR_IN, COR_LOG_OUT, m, MSG_NUM_IN = 5'h00;
  logic [1:0] MSG_TYPE_IN;
  logic [15:0] MSG_RID_IN, SELF_ID_IN = 16'h0000, ra, rb, rc, sid;
  logic [2:0] REPORT_OUT;
  logic [127:0] h1, h2, h3;
  logic [32:0] rdq [$];
  logic [7:0] evq [$];
  logic [11:0] ofs [12] = '{OFS_SEV, OFS_COR_STS, OFS_COR_MSK, OFS_CAP_CTRL, OFS_HDR0, OFS_HDR1,
    OFS_HDR2, OFS_HDR3, OFS_ROOT_CMD, OFS_ROOT_STS, OFS_SRC_ID, 12'h200};
  int num_errors = 0, n_compared = 0;
  // ----
  // clock, design and far side
  // ----
  always #4 CLK_IN = ~CLK_IN;
  aerl_top u_aerl_top (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .WARM_RST_N_IN(WARM_RST_N_IN),
    .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
    .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
    .COR_ERR_IN(COR_ERR_IN), .UNCOR_ERR_IN(UNCOR_ERR_IN), .UNCOR_SEV_IN(UNCOR_SEV_IN),
    .SELF_ID_IN(SELF_ID_IN), .HDR0_IN(hdr[0]), .HDR1_IN(hdr[1]), .HDR2_IN(hdr[2]),
    .HDR3_IN(hdr[3]), .LOG_UNLOCK_IN(LOG_UNLOCK_IN), .MSG_VALID_IN(MSG_VALID_IN),
    .MSG_TYPE_IN(MSG_TYPE_IN), .MSG_RID_IN(MSG_RID_IN), .MSG_NUM_IN(MSG_NUM_IN),
    .COR_LOG_OUT(COR_LOG_OUT), .REPORT_OUT(REPORT_OUT), .SEVERITY_OUT(SEVERITY_OUT));
  aerl_link_model u_aerl_link_model (.clk_in(CLK_IN), .cor_out(COR_ERR_IN),
    .unc_out(UNCOR_ERR_IN), .sev_out(UNCOR_SEV_IN), .hdr_out(hdr), .unlock_out(LOG_UNLOCK_IN),
    .mv_out(MSG_VALID_IN), .mt_out(MSG_TYPE_IN), .rid_out(MSG_RID_IN));
  // ----
  // helpers
  // ----
  task automatic check(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // classic cycle: hold until ack is sampled, then one idle cycle follows
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] e);
    int n;
    @(posedge CLK_IN);
    WB_CYC_IN <= 1'b1;
    WB_STB_IN <= 1'b1;
    WB_WE_IN <= we;
    WB_ADR_IN <= a;
    WB_DAT_IN <= d;
    rdq.push_back({~we, e});
    n = 0;
    do begin
      @(posedge CLK_IN);
      n++;
    end while (WB_ACK_OUT !== 1'b1 && n < 50);
    if (WB_ACK_OUT !== 1'b1) begin
      num_errors++;
      stop_test();
    end else begin
      WB_CYC_IN <= 1'b0;
      WB_STB_IN <= 1'b0;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 32'h0);
  endtask
  task automatic msg(input logic [1:0] t, input logic [15:0] r, input logic [2:0] rep);
    if (rep !== 3'h0) evq.push_back({5'h00, rep});
    u_aerl_link_model.ev(5'h00, 32'h0, 32'h0, 1'b0, 1'b1, t, r, 128'h0);
  endtask
  task automatic unc(input logic [31:0] u, input logic [31:0] s, input logic [127:0] h,
    input logic [2:0] rep);
    evq.push_back({5'h00, rep});
    u_aerl_link_model.ev(5'h00, u, s, 1'b0, 1'b0, 2'h0, 16'h0, h);
  endtask
  // watcher: each ack and each pulse takes the oldest note
  always @(posedge CLK_IN) begin
    logic [32:0] r;
    logic [7:0] n;
    if (WB_ACK_OUT === 1'b1) begin
      // an ack with no request behind it counts as a mismatch
      if (rdq.size() == 0) begin
        num_errors++;
        $display("[ERR] %0t exp %h got %h", $time, 1'b0, WB_ACK_OUT);
      end
      r = (rdq.size() > 0) ? rdq.pop_front() : 33'h0;
      if (r[32]) check(r[31:0], WB_DAT_OUT);
    end
    if (COR_LOG_OUT !== 5'h00 || REPORT_OUT !== 3'h0) begin
      n = (evq.size() > 0) ? evq.pop_front() : 8'hFF;
      check({24'h0, n}, {24'h0, COR_LOG_OUT, REPORT_OUT});
    end
  end
  // hang guard, far beyond the longest sequence
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(54));
    m = 5'($urandom());
    {ra, rb} = $urandom();
    {rc, sid} = $urandom();
    h1 = {$urandom(), $urandom(), $urandom(), $urandom()};
    h2 = ~h1;
    h3 = {$urandom(), $urandom(), $urandom(), $urandom()};
    repeat (2) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    MSG_NUM_IN <= m;
    SELF_ID_IN <= sid;
    check(32'h11, SEVERITY_OUT);
    foreach (ofs[i])
      rd(ofs[i], ofs[i] == OFS_SEV ? 32'h11 : ofs[i] == OFS_ROOT_STS ? {m, 27'h0} : 32'h0);
    wr(12'h200, 32'hFFFFFFFF);
    rd(12'h200, 32'h0);
    $display("test reset done");
    wr(OFS_COR_MSK, 32'h100);
    evq.push_back({5'h17, 3'h0});
    u_aerl_link_model.ev(5'h1F, 32'h0, 32'h0, 1'b0, 1'b0, 2'h0, 16'h0, 128'h0);
    rd(OFS_COR_STS, 32'h11C1);
    rd(OFS_ROOT_STS, {m, 27'h1});
    rd(OFS_SRC_ID, {16'h0, sid});
    wr(OFS_COR_STS, 32'h40);
    rd(OFS_COR_STS, 32'h1181);
    // only byte 0 enabled: bits 7:0 of the mask land, bit 8 keeps its value
    WB_SEL_IN <= 4'h1;
    wr(OFS_COR_MSK, 32'hFFFFFFFF);
    WB_SEL_IN <= 4'hF;
    rd(OFS_COR_MSK, 32'h1C1);
    $display("test correctable done");
    wr(OFS_ROOT_CMD, 32'h7);
    rd(OFS_ROOT_CMD, 32'h7);
    msg(MSG_COR, ra, 3'h1);
    rd(OFS_ROOT_STS, {m, 27'h3});
    msg(MSG_NF, rb, 3'h2);
    msg(MSG_FAT, ra, 3'h4);
    rd(OFS_ROOT_STS, {m, 27'h6F});
    rd(OFS_SRC_ID, {rb, sid});
    wr(OFS_ROOT_STS, 32'h0);
    rd(OFS_ROOT_STS, {m, 27'h6F});
    wr(OFS_ROOT_STS, 32'hFFFFFFFF);
    rd(OFS_ROOT_STS, {m, 27'h0});
    msg(MSG_FAT, rc, 3'h4);
    rd(OFS_ROOT_STS, {m, 27'h54});
    rd(OFS_SRC_ID, {rc, sid});
    msg(MSG_NF, rb, 3'h2);
    rd(OFS_ROOT_STS, {m, 27'h7C});
    $display("test root status done");
    unc(32'h00042000, 32'h0, h1, 3'h2);
    rd(OFS_CAP_CTRL, 32'h12);
    for (int i = 0; i < 4; i++) rd(OFS_HDR0 + 12'(4 * i), h1[32*i +: 32]);
    unc(32'h1000, 32'h1000, h2, 3'h4);
    wr(OFS_CAP_CTRL, 32'hFFFFFFFF);
    rd(OFS_CAP_CTRL, 32'h12);
    rd(OFS_HDR3, h1[127:96]);
    u_aerl_link_model.ev(5'h00, 32'h0, 32'h0, 1'b1, 1'b0, 2'h0, 16'h0, 128'h0);
    unc(32'h1000, 32'h0, h3, 3'h2);
    rd(OFS_CAP_CTRL, 32'h0C);
    rd(OFS_HDR0, h3[31:0]);
    $display("test header log done");
    // keep the training severity bit as it resets
    wr(OFS_SEV, 32'h21);
    check(32'h21, SEVERITY_OUT);
    @(posedge CLK_IN);
    WARM_RST_N_IN <= 1'b0;
    repeat (4) @(posedge CLK_IN);
    WARM_RST_N_IN <= 1'b1;
    repeat (4) @(posedge CLK_IN);
    rd(OFS_ROOT_CMD, 32'h0);
    rd(OFS_COR_STS, 32'h1181);
    rd(OFS_COR_MSK, 32'h1C1);
    rd(OFS_SEV, 32'h21);
    rd(OFS_HDR0, h3[31:0]);
    rd(OFS_SRC_ID, {rc, sid});
    msg(MSG_COR, ra, 3'h0);
    rd(OFS_ROOT_STS, {m, 27'h7D});
    rd(OFS_SRC_ID, {rc, ra});
    $display("test warm reset done");
    repeat (4) @(posedge CLK_IN);
    if (evq.size() != 0 || rdq.size() != 0) num_errors++;
    stop_test();
  end
endmodule
